// ---- verilog/fsg_pkg.sv ----
/*
  Shared constants and types of the flash status and write-guard controller.
  Assumes a 125 MHz system clock; access and write-pulse cycle counts derive from CLK_NS.
*/
package fsg_pkg;
  // Clock and flash timing
  localparam int CLK_NS = 8;
  localparam int T_ACC_NS = 100;
  localparam int T_WP_NS = 50;
  localparam int SYNC_CYC = 2;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] RD_WAIT = 5'(ACC_CYC + SYNC_CYC);
  localparam logic [4:0] WR_WAIT = 5'(WP_CYC);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_WORD = 3;
  localparam int CTRL_CMD8 = 4;
  localparam int CTRL_CONT = 5;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RES = 2;
  localparam int ST_RDY = 5;
  localparam int ST_TA = 6;
  localparam int ST_TB = 7;
  // Status bit positions on the flash data bus
  localparam int DQ_TOG_A = 6;
  localparam int DQ_TOG_B = 2;
  localparam int DQ_TIMEOUT = 5;
  // Command and reset values
  localparam logic [7:0] RESET_CMD = 8'hF0;
  localparam logic WORD_RST = 1'b1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_POLL, OP_RESET} fsg_op_t;
  typedef enum logic [2:0] {RES_NONE, RES_PASS, RES_FAIL, RES_SUSP, RES_RUN} fsg_res_t;
  typedef enum logic [3:0] {S_IDLE, S_CYC, P_RD1, P_RD2, P_RD3, P_RD4, P_DATA, P_RST} fsg_state_t;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fsg_cyc_t;
endpackage

// ---- verilog/fsg_if.sv ----
/*
  Interfaces between the controller's modules: bus-cycle requests and register access.
  Assumes all parties run on the same clock.
*/
`timescale 1ns/100ps
interface fsg_cyc_if #(parameter int AW = 22);
  logic req;
  logic wr;
  logic cmd8;
  logic word;
  logic [AW-1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport ctl(output req, wr, cmd8, word, addr, wdata, input rdata, ack);
  modport eng(input req, wr, cmd8, word, addr, wdata, output rdata, ack);
endinterface

interface fsg_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wok;
  logic [7:0] raddr;
  logic [31:0] rdata;
  logic rok;
  modport slv(output wr, waddr, wdata, wstrb, raddr, input wok, rdata, rok);
  modport core(input wr, waddr, wdata, wstrb, raddr, output wok, rdata, rok);
endinterface

// ---- verilog/fsg_axil.sv ----
/*
  AXI4-Lite slave that turns bus transfers into register strobes.
  Assumes the core answers decode combinationally from the presented address.
*/
`timescale 1ns/100ps
module fsg_axil (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // AXI4-Lite
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side
  fsg_reg_if.slv r
);
  logic aw_have_q, w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire do_wr = aw_have_q && w_have_q && !bvalid;
  wire ar_take = arvalid && arready;
  wire aw_have_d = (aw_have_q || aw_take) && !do_wr;
  wire w_have_d = (w_have_q || w_take) && !do_wr;
  wire bvalid_d = do_wr || (bvalid && !bready);
  wire rvalid_d = ar_take || (rvalid && !rready);

  assign r.wr = do_wr;
  assign r.waddr = {awaddr_q[7:2], 2'b00};
  assign r.wdata = wdata_q;
  assign r.wstrb = wstrb_q;
  assign r.raddr = {araddr[7:2], 2'b00};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= fsg_pkg::RESP_OK;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= fsg_pkg::RESP_OK;
    end else if (clk_en) begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      if (aw_take) awaddr_q <= awaddr;
      if (w_take) wdata_q <= wdata;
      if (w_take) wstrb_q <= wstrb;
      awready <= !aw_have_d && !bvalid_d;
      wready <= !w_have_d && !bvalid_d;
      bvalid <= bvalid_d;
      if (do_wr) bresp <= r.wok ? fsg_pkg::RESP_OK : fsg_pkg::RESP_ERR;
      arready <= !rvalid_d;
      rvalid <= rvalid_d;
      if (ar_take) rdata <= r.rok ? r.rdata : 32'h00000000;
      if (ar_take) rresp <= r.rok ? fsg_pkg::RESP_OK : fsg_pkg::RESP_ERR;
    end
  end
endmodule // fsg_axil

// ---- verilog/fsg_cycle.sv ----
/*
  Flash bus-cycle engine: one read or one write cycle per request.
  Assumes flash data inputs are asynchronous; they pass two flip-flops.
*/
`timescale 1ns/100ps
module fsg_cycle #(
  parameter int AW = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Requests
  fsg_cyc_if.eng c,
  // Flash pins
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-2:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe
);
  fsg_pkg::fsg_cyc_t st_q;
  logic [4:0] cnt_q;
  logic wr_q, word_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic [15:0] rdata_q;
  logic ack_q;
  wire take = (st_q == fsg_pkg::C_IDLE) && c.req && !ack_q;
  wire cnt_end = (cnt_q == 5'h01);
  // Command cycles are byte cycles; in word mode the byte goes out on both lanes
  wire [15:0] wd = c.cmd8 ? {c.wdata[7:0], c.wdata[7:0]} : c.wdata;
  wire [15:0] dq_v = c.word ? wd : {c.addr[0], 7'h00, wd[7:0]};
  wire [15:0] oe_v = c.word ? {16{c.wr}} : {1'b1, 7'h00, {8{c.wr}}};
  wire [AW-2:0] fa_v = c.word ? c.addr[AW-2:0] : c.addr[AW-1:1];

  assign c.rdata = rdata_q;
  assign c.ack = ack_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= fsg_pkg::C_IDLE;
      cnt_q <= 5'h00;
      wr_q <= 1'b0;
      word_q <= 1'b1;
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      flash_ce_b <= 1'b1;
      flash_oe_b <= 1'b1;
      flash_we_b <= 1'b1;
      flash_addr <= '0;
      flash_dq_o <= 16'h0000;
      flash_dq_oe <= 16'h0000;
    end else if (clk_en) begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      ack_q <= 1'b0;
      case (st_q)
        fsg_pkg::C_IDLE: if (take) begin
          // CE low with OE and WE high before any strobe
          st_q <= fsg_pkg::C_SETUP;
          wr_q <= c.wr;
          word_q <= c.word;
          flash_ce_b <= 1'b0;
          flash_addr <= fa_v;
          flash_dq_o <= dq_v;
          flash_dq_oe <= oe_v;
        end
        fsg_pkg::C_SETUP: begin
          st_q <= fsg_pkg::C_STROBE;
          cnt_q <= wr_q ? fsg_pkg::WR_WAIT : fsg_pkg::RD_WAIT;
          flash_we_b <= !wr_q;
          flash_oe_b <= wr_q;
        end
        fsg_pkg::C_STROBE: begin
          cnt_q <= cnt_q - 5'h01;
          if (cnt_end) begin
            st_q <= fsg_pkg::C_HOLD;
            flash_we_b <= 1'b1;
            flash_oe_b <= 1'b1;
            if (!wr_q) rdata_q <= word_q ? dq_s2_q : {8'h00, dq_s2_q[7:0]};
          end
        end
        default: begin
          // CE rises between cycles so every poll read is a fresh access
          st_q <= fsg_pkg::C_IDLE;
          flash_ce_b <= 1'b1;
          flash_dq_oe <= 16'h0000;
          ack_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  write_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    !flash_we_b |-> !flash_ce_b && flash_oe_b)
    else $error("write strobe without CE low and OE high");
  strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(flash_we_b) |-> $past(!flash_ce_b) && flash_dq_oe[0])
    else $error("write strobe without setup");
endmodule // fsg_cycle

// ---- verilog/fsg_top.sv ----
/*
  Host-side controller for an asynchronous parallel flash: register-driven
  reads, writes, reset command and toggle-bit status polling.
  Assumes AXI4-Lite software access, one clock, and an external pull-up on
  the flash ready/busy line.
*/
// Function
// - B toggling, A steady means suspended read
// - Polling starts with two back-to-back reads
// - Steady toggle means done; next read data
// - Timeout high while toggling: check once more
// - Failed operation: write the reset command
// - Write needs CE, WE low, OE high
`timescale 1ns/100ps
module fsg_top #(
  parameter int AW = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // AXI4-Lite
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Flash pins
  output logic flash_ce_b,
  output logic flash_oe_b,
  output logic flash_we_b,
  output logic [AW-2:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  output logic word_mode,
  input wire logic ready_busy_out
);
  fsg_reg_if r ();
  fsg_cyc_if #(.AW(AW)) c ();

  fsg_pkg::fsg_state_t state_q, state_d;
  fsg_pkg::fsg_res_t res_q, res_d;
  fsg_pkg::fsg_op_t op_q;
  logic [1:0] tog1_q;
  logic done_q, cmd8_q, cont_q, word_q;
  logic [AW-1:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic rb_s1_q, rb_s2_q;
  logic fin, tog_ld;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[8*i +: 8] = n[8*i +: 8];
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  fsg_axil u_axil (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .r(r)
  );

  fsg_cycle #(.AW(AW)) u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .c(c),
    .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b),
    .flash_we_b(flash_we_b),
    .flash_addr(flash_addr),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire idle = (state_q == fsg_pkg::S_IDLE);
  wire wr_ctrl = r.wr && (r.waddr == fsg_pkg::OFS_CTRL);
  wire wr_addr = r.wr && (r.waddr == fsg_pkg::OFS_ADDR);
  wire wr_wdata = r.wr && (r.waddr == fsg_pkg::OFS_WDATA);
  wire wr_ro = r.wr && (r.waddr == fsg_pkg::OFS_STATUS || r.waddr == fsg_pkg::OFS_RDATA);
  // Settings are frozen while busy; a running sequence must not see them move
  wire [31:0] ctrl_rd = {26'h0, cont_q, cmd8_q, word_q, op_q, 1'b0};
  wire [31:0] ctrl_new = merge(ctrl_rd, r.wdata, r.wstrb);
  wire [31:0] addr_new = merge(32'(addr_q), r.wdata, r.wstrb);
  wire [31:0] wdata_new = merge({16'h0, wdata_q}, r.wdata, r.wstrb);
  wire start_ok = wr_ctrl && idle && r.wstrb[0] && r.wdata[fsg_pkg::CTRL_START];
  wire fsg_pkg::fsg_op_t op_new = fsg_pkg::fsg_op_t'(ctrl_new[fsg_pkg::CTRL_OP +: 2]);
  wire [31:0] status_rd = {24'h0, tog1_q, rb_s2_q, res_q, done_q, !idle};
  assign r.wok = wr_ctrl || wr_addr || wr_wdata || wr_ro;
  assign r.rok = (r.raddr == fsg_pkg::OFS_CTRL) || (r.raddr == fsg_pkg::OFS_ADDR) ||
                 (r.raddr == fsg_pkg::OFS_WDATA) || (r.raddr == fsg_pkg::OFS_STATUS) ||
                 (r.raddr == fsg_pkg::OFS_RDATA);
  assign r.rdata = (r.raddr == fsg_pkg::OFS_CTRL) ? ctrl_rd :
                   (r.raddr == fsg_pkg::OFS_ADDR) ? 32'(addr_q) :
                   (r.raddr == fsg_pkg::OFS_WDATA) ? {16'h0, wdata_q} :
                   (r.raddr == fsg_pkg::OFS_STATUS) ? status_rd :
                   (r.raddr == fsg_pkg::OFS_RDATA) ? {16'h0, rdata_q} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle requests: the address is the sector address for every poll read
  wire in_rst = (state_q == fsg_pkg::P_RST);
  wire s_cyc = (state_q == fsg_pkg::S_CYC);
  assign c.req = !idle;
  assign c.wr = in_rst || (s_cyc && op_q != fsg_pkg::OP_READ);
  assign c.cmd8 = in_rst || (s_cyc && op_q == fsg_pkg::OP_RESET) || cmd8_q;
  assign c.word = word_q;
  assign c.addr = addr_q;
  assign c.wdata = (in_rst || op_q == fsg_pkg::OP_RESET) ? {8'h00, fsg_pkg::RESET_CMD} : wdata_q;
  wire chg_a = c.rdata[fsg_pkg::DQ_TOG_A] != tog1_q[1];
  wire chg_b = c.rdata[fsg_pkg::DQ_TOG_B] != tog1_q[0];
  wire tmo = c.rdata[fsg_pkg::DQ_TIMEOUT];

  ////////////////////////////////////////////////////////////////////////////
  // Polling sequence
  always_comb begin
    state_d = state_q;
    res_d = res_q;
    fin = 1'b0;
    tog_ld = 1'b0;
    case (state_q)
      fsg_pkg::S_IDLE: if (start_ok) begin
        state_d = (op_new == fsg_pkg::OP_POLL) ? fsg_pkg::P_RD1 : fsg_pkg::S_CYC;
        res_d = fsg_pkg::RES_NONE;
      end
      fsg_pkg::S_CYC: if (c.ack) begin
        state_d = fsg_pkg::S_IDLE;
        res_d = fsg_pkg::RES_PASS;
        fin = 1'b1;
      end
      fsg_pkg::P_RD1, fsg_pkg::P_RD3: if (c.ack) begin
        tog_ld = 1'b1;
        state_d = (state_q == fsg_pkg::P_RD1) ? fsg_pkg::P_RD2 : fsg_pkg::P_RD4;
      end
      fsg_pkg::P_RD2: if (c.ack) begin
        tog_ld = 1'b1;
        if (!chg_a && chg_b) begin
          state_d = fsg_pkg::S_IDLE;
          res_d = fsg_pkg::RES_SUSP;
          fin = 1'b1;
        end else if (!chg_a) begin
          state_d = fsg_pkg::P_DATA;
        end else if (tmo) begin
          state_d = fsg_pkg::P_RD3;
        end else if (cont_q) begin
          state_d = fsg_pkg::P_RD1;
        end else begin
          state_d = fsg_pkg::S_IDLE;
          res_d = fsg_pkg::RES_RUN;
          fin = 1'b1;
        end
      end
      fsg_pkg::P_RD4: if (c.ack) begin
        state_d = chg_a ? fsg_pkg::P_RST : fsg_pkg::P_DATA;
      end
      fsg_pkg::P_DATA: if (c.ack) begin
        state_d = fsg_pkg::S_IDLE;
        res_d = fsg_pkg::RES_PASS;
        fin = 1'b1;
      end
      default: if (c.ack) begin
        state_d = fsg_pkg::S_IDLE;
        res_d = fsg_pkg::RES_FAIL;
        fin = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fsg_pkg::S_IDLE;
      res_q <= fsg_pkg::RES_NONE;
      op_q <= fsg_pkg::OP_READ;
      tog1_q <= 2'h0;
      done_q <= 1'b0;
      cmd8_q <= 1'b0;
      cont_q <= 1'b0;
      word_q <= fsg_pkg::WORD_RST;
      word_mode <= fsg_pkg::WORD_RST;
      addr_q <= '0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else if (clk_en) begin
      state_q <= state_d;
      res_q <= res_d;
      done_q <= fin || (done_q && !start_ok);
      rb_s1_q <= ready_busy_out;
      rb_s2_q <= rb_s1_q;
      if (tog_ld) tog1_q <= {c.rdata[fsg_pkg::DQ_TOG_A], c.rdata[fsg_pkg::DQ_TOG_B]};
      if (c.ack && !c.wr) rdata_q <= c.rdata;
      if (wr_ctrl && idle) begin
        op_q <= op_new;
        word_q <= ctrl_new[fsg_pkg::CTRL_WORD];
        word_mode <= ctrl_new[fsg_pkg::CTRL_WORD];
        cmd8_q <= ctrl_new[fsg_pkg::CTRL_CMD8];
        cont_q <= ctrl_new[fsg_pkg::CTRL_CONT];
      end
      if (wr_addr && idle) addr_q <= addr_new[AW-1:0];
      if (wr_wdata && idle) wdata_q <= wdata_new[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire ack_rd2 = (state_q == fsg_pkg::P_RD2) && c.ack && clk_en;
  poll_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    (start_ok && clk_en && op_new == fsg_pkg::OP_POLL) |=> state_q == fsg_pkg::P_RD1 && c.req && !c.wr)
    else $error("poll did not begin with a read");
  two_reads_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_q == fsg_pkg::P_RD1) && c.ack && clk_en) |=> state_q == fsg_pkg::P_RD2)
    else $error("poll decided after one read");
  susp_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ack_rd2 && !chg_a && chg_b) |=> res_q == fsg_pkg::RES_SUSP && done_q && idle)
    else $error("suspended read not reported");
  done_data_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ack_rd2 && !chg_a && !chg_b) |=> state_q == fsg_pkg::P_DATA ##0 c.req && !c.wr)
    else $error("no data read after toggling stopped");
  data_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_q == fsg_pkg::P_DATA) && c.ack && clk_en) |=> rdata_q == $past(c.rdata) && res_q == fsg_pkg::RES_PASS)
    else $error("array data not captured");
  recheck_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ack_rd2 && chg_a && tmo) |=> state_q == fsg_pkg::P_RD3)
    else $error("timeout seen without recheck");
  reset_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_q == fsg_pkg::P_RD4) && c.ack && clk_en && chg_a) |=>
      c.req && c.wr && c.wdata[7:0] == fsg_pkg::RESET_CMD && c.cmd8)
    else $error("failed operation without reset command");
  fail_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (res_q == fsg_pkg::RES_FAIL && done_q) |-> $past(state_q == fsg_pkg::P_RST) || $past(res_q == fsg_pkg::RES_FAIL))
    else $error("failure reported without reset command");
  tog_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_q == fsg_pkg::P_RD1) && c.ack && clk_en) |=>
      tog1_q == {$past(c.rdata[fsg_pkg::DQ_TOG_A]), $past(c.rdata[fsg_pkg::DQ_TOG_B])})
    else $error("first poll read not stored");
  // Toggling with timeout low and no repeat hands the decision back to software
  still_run_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ack_rd2 && chg_a && !tmo && !cont_q) |=> res_q == fsg_pkg::RES_RUN && done_q && idle)
    else $error("running operation not reported");
  pass_c: cover property (@(posedge clk) disable iff (!rst_b)
    (state_q == fsg_pkg::P_DATA) ##1 idle && res_q == fsg_pkg::RES_PASS);
  susp_c: cover property (@(posedge clk) disable iff (!rst_b) res_q == fsg_pkg::RES_SUSP && done_q);
  fail_c: cover property (@(posedge clk) disable iff (!rst_b) res_q == fsg_pkg::RES_FAIL && done_q);
  byte_c: cover property (@(posedge clk) disable iff (!rst_b) !word_mode && !flash_we_b);
endmodule // fsg_top

// ---- bench/fsg_flash_model.sv ----
/*
  Behavioural flash: toggle status bits, ready/busy and the reset command.
  Assumes the bench sets mode directly and resolves the shared data bus.
*/
`timescale 1ns/100ps
module fsg_flash_model (
  // Flash pins
  input wire logic ce_b,
  input wire logic oe_b,
  input wire logic we_b,
  input wire logic word_mode,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic busy_low
);
  // Modes: 0 array, 1 program, 2 erase, 3 suspend read, 4 timed out
  logic [2:0] mode = 3'h0;
  logic tog_a = 1'b0;
  logic tog_b = 1'b0;
  logic clash = 1'b0;
  logic [7:0] last_cmd = 8'h00;
  logic [15:0] hold = 16'h0000;
  logic [15:0] arr;
  logic [7:0] st;
  logic [15:0] val;
  logic run;
  ////////////////////////////////////////
  assign run = mode == 3'h1 || mode == 3'h2 || mode == 3'h4;
  assign arr = {addr[7:0] ^ 8'h5A, addr[7:0]};
  assign st = {mode == 3'h3 || ~arr[7], mode == 3'h3 || tog_a, mode == 3'h4, 1'b0, mode == 3'h2,
    mode[1] ? tog_b : 1'b1, 2'b00};
  assign val = mode != 3'h0 ? {8'h00, st} : word_mode ? arr : {8'h00, dq_in[15] ? arr[15:8] : arr[7:0]};
  // Released lines show the inverse of the last value, never a kind zero
  assign dq_out = ce_b || oe_b ? ~hold : word_mode ? val : {~hold[15:8], val[7:0]};
  // Bench enters a running mode directly, standing for the last write pulse
  assign busy_low = run;
  always @(posedge oe_b) hold <= val;
  always @(negedge oe_b) if (!ce_b) begin
    tog_a <= run ? ~tog_a : tog_a;
    tog_b <= mode[1] ? ~tog_b : tog_b;
  end
  always @(negedge we_b) if (!oe_b) clash <= 1'b1;
  always @(posedge we_b) if (!ce_b && oe_b) begin
    last_cmd <= dq_in[15:8];
    if (dq_in[15:8] == 8'hF0 && mode != 3'h1 && mode != 3'h2) mode <= 3'h0;
  end
endmodule // fsg_flash_model

// ---- bench/fsg_top_tb.sv ----
/*
  Self-checking bench of the flash controller against a behavioural flash.
  Assumes a 125 MHz clock and a pull-up on the ready/busy line.
*/
`timescale 1ns/100ps
module fsg_top_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, ce_b, oe_b, we_b, word_mode, busy_low;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, s;
  logic [20:0] faddr;
  logic [15:0] dq_o, dq_oe, dq_out, dq_i;
  int failures = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////
  always #4 clk = ~clk;
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & dq_out);
  fsg_top #(.AW(22)) fsg_top_inst (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b), .flash_addr(faddr), .flash_dq_i(dq_i),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .word_mode(word_mode), .ready_busy_out(~busy_low));
  fsg_flash_model fsg_flash_model_inst (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .word_mode(word_mode),
    .addr(faddr), .dq_in(dq_i), .dq_out(dq_out), .busy_low(busy_low));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    s = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Start an operation and read status until the engine is idle
  task automatic run_op(input logic [31:0] adr, input logic [31:0] ctl);
    axw(fsg_pkg::OFS_ADDR, adr);
    axw(fsg_pkg::OFS_CTRL, ctl);
    do axr(fsg_pkg::OFS_STATUS); while (s[fsg_pkg::ST_BUSY] !== 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    axr(fsg_pkg::OFS_STATUS);
    chk(s, 32'h20);
    chk(word_mode, 1'b1);
    axr(8'h14);
    chk(r, fsg_pkg::RESP_ERR);
    axw(8'h14, 32'h00000000);
    chk(r, fsg_pkg::RESP_ERR);
    // Upper half must not land in the 16-bit data register
    axw(fsg_pkg::OFS_WDATA, 32'hFFFF5A5A);
    chk(r, fsg_pkg::RESP_OK);
    axr(fsg_pkg::OFS_WDATA);
    chk(s, 32'h5A5A);
  endtask
  // Reset-command op, then a byte command that must reach the upper lanes
  task automatic t_write;
    run_op(32'h40, 32'hF);
    chk(fsg_flash_model_inst.last_cmd, fsg_pkg::RESET_CMD);
    axw(fsg_pkg::OFS_WDATA, 32'hAA);
    run_op(32'h40, 32'h1B);
    chk(s[4:2], fsg_pkg::RES_PASS);
    chk(fsg_flash_model_inst.last_cmd, 8'hAA);
  endtask
  task automatic t_read;
    run_op(32'h12, 32'h9);
    axr(fsg_pkg::OFS_RDATA);
    chk(s, 32'h4812);
    run_op(32'h25, 32'h1);
    chk(word_mode, 1'b0);
    axr(fsg_pkg::OFS_RDATA);
    chk(s, 32'h48);
  endtask
  // Every device mode once; the timed-out one must end in a reset command
  task automatic t_poll;
    fsg_pkg::fsg_res_t ex [5] = '{fsg_pkg::RES_PASS, fsg_pkg::RES_RUN, fsg_pkg::RES_RUN,
      fsg_pkg::RES_SUSP, fsg_pkg::RES_FAIL};
    for (int i = 0; i < 5; i++) begin
      fsg_flash_model_inst.mode = 3'(i);
      run_op(32'h40, 32'hD);
      chk(s[4:2], ex[i]);
      chk(s[5], i != 1 && i != 2);
      if (i == 0) begin
        axr(fsg_pkg::OFS_RDATA);
        chk(s, 32'h1A40);
      end
    end
    chk(fsg_flash_model_inst.mode, 3'h0);
    chk(fsg_flash_model_inst.last_cmd, fsg_pkg::RESET_CMD);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_read();
    t_write();
    t_poll();
    chk(fsg_flash_model_inst.clash, 1'b0);
    close_out();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
endmodule // fsg_top_tb
